// File: rtl/ues_top.sv
`default_nettype none

module ues_top
  import ues_pkg::*;
#(
  parameter int NUM_CTR = 2,
  parameter int CTR_W   = 32
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,

  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,

  input  wire logic [2:0]  cancel_req,
  input  wire logic [2:0]  crit_req_valid,
  input  wire logic [2:0]  crit_req_match,
  output logic [2:0]       prio_update,
  input  wire logic        frc_ack_sent,
  input  wire logic [5:0]  sf_pending,
  input  wire logic [5:0]  sf_shared_credit,
  input  wire logic [5:0]  sf_dedicated_credit,
  input  wire logic [5:0]  mf_pending,
  input  wire logic [5:0]  mf_shared_credit,
  input  wire logic [5:0]  mf_dedicated_credit,
  input  wire logic [1:0]  hdr_buf_busy,
  input  wire logic [1:0]  snoop_pending,
  input  wire logic        peer_probe_tracker_free,
  input  wire logic [2:0]  access_req,
  input  wire logic [2:0]  idle_expired,
  output logic [2:0]       access_ack,
  output logic [5:0]       dram_cmd
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (NUM_CTR < 1 || NUM_CTR > 4) begin : g_bad_num
    $error("NUM_CTR must be 1 to 4");
  end
  if (CTR_W < 2 || CTR_W > 32) begin : g_bad_w
    $error("CTR_W must be 2 to 32");
  end

  // ----------------------------------------
  // Credit and snoop stall terms
  // ----------------------------------------
  logic [5:0] sf_stall;
  logic [5:0] mf_stall;
  logic [1:0] snp_stall;

  assign sf_stall  = sf_pending & ~sf_shared_credit
                     & ~sf_dedicated_credit;
  assign mf_stall  = mf_pending & ~mf_shared_credit
                     & ~mf_dedicated_credit;
  assign snp_stall = snoop_pending & {2{~peer_probe_tracker_free}};

  // ----------------------------------------
  // Priority update issue
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_update <= 3'h0;
    end else begin
      prio_update <= crit_req_valid & crit_req_match;
    end
  end

  // ----------------------------------------
  // Page tracker per channel
  // ----------------------------------------
  logic [2:0] page_open_now;
  logic [2:0] open_ev;
  logic [2:0] close_ev;

  for (genvar c = 0; c < 3; c++) begin : g_page
    ues_page_type pg_reg;
    ues_page_type pg_next;
    logic [1:0]   cmd_next;

    always_comb begin
      pg_next  = pg_reg;
      cmd_next = CMD_NONE;
      case (pg_reg)
        PG_CLOSED: begin
          if (access_req[c]) begin
            cmd_next = CMD_OPEN;
            pg_next  = PG_OPENED;
          end
        end
        PG_OPENED: begin
          if (access_req[c]) begin
            cmd_next = CMD_RW;
          end else if (idle_expired[c]) begin
            cmd_next = CMD_PRE;
            pg_next  = PG_CLOSED;
          end
        end
        default: begin
          pg_next = PG_CLOSED;
        end
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pg_reg <= PG_CLOSED;
      end else begin
        pg_reg <= pg_next;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dram_cmd[2*c +: 2] <= CMD_NONE;
        access_ack[c]      <= 1'b0;
      end else begin
        dram_cmd[2*c +: 2] <= cmd_next;
        access_ack[c]      <= (cmd_next == CMD_RW);
      end
    end

    assign page_open_now[c] = (pg_reg == PG_OPENED);
    assign open_ev[c]  = (dram_cmd[2*c +: 2] == CMD_OPEN);
    assign close_ev[c] = (dram_cmd[2*c +: 2] == CMD_PRE);
  end

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_full_reg;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic        wr_hit;

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign wr_fire       = aw_full_reg && w_full_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write decode and response
  // ----------------------------------------
  assign wr_idx = (aw_addr_reg - OFS_SEL0) / OFS_STRIDE;
  assign wr_hit = (aw_addr_reg[1:0] == 2'h0)
                  && (aw_addr_reg < OFS_STRIDE * 8'(NUM_CTR));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [16:0]      sel_q [NUM_CTR];
  logic [CTR_W-1:0] cnt_q [NUM_CTR];
  logic [NUM_CTR-1:0] ctr_hit;

  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    logic [16:0]      sel_reg;
    logic [CTR_W-1:0] cnt_reg;
    logic [CTR_W-1:0] cnt_next;
    logic [CTR_W-1:0] base;
    logic             hit;
    logic [1:0]       inc;
    logic             sel_wr;
    logic             cnt_wr;

    assign sel_wr = wr_fire && wr_hit && wr_idx == 8'(i)
                    && aw_addr_reg[2:0] == OFS_SEL0[2:0];
    assign cnt_wr = wr_fire && wr_hit && wr_idx == 8'(i)
                    && aw_addr_reg[2:0] == OFS_CNT0[2:0];

    ues_event_mux u_mux (
      .code       (sel_reg[SEL_CODE_LSB +: 8]),
      .umask      (sel_reg[SEL_UMASK_LSB +: 8]),
      .cancel_ev  (cancel_req),
      .prio_ev    (prio_update),
      .frc_ack_ev (frc_ack_sent),
      .sf_stall   (sf_stall),
      .mf_stall   (mf_stall),
      .hdr_busy   (hdr_buf_busy),
      .snp_stall  (snp_stall),
      .open_ev    (open_ev),
      .close_ev   (close_ev),
      .hit        (hit),
      .inc        (inc)
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sel_reg <= SEL_RST;
      end else if (sel_wr) begin
        for (int b = 0; b < 2; b++) begin
          if (w_strb_reg[b]) begin
            sel_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
          end
        end
        if (w_strb_reg[2]) begin
          sel_reg[SEL_EN_BIT] <= w_data_reg[SEL_EN_BIT];
        end
      end
    end

    always_comb begin
      base = cnt_reg;
      if (cnt_wr) begin
        base = w_data_reg[CTR_W-1:0];
      end
      cnt_next = base;
      if (sel_reg[SEL_EN_BIT] && hit) begin
        cnt_next = base + CTR_W'(inc);
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_next;
      end
    end

    assign sel_q[i]   = sel_reg;
    assign cnt_q[i]   = cnt_reg;
    assign ctr_hit[i] = hit;
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  logic [7:0]  rd_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr / OFS_STRIDE;

  always_comb begin
    rd_data = 32'h00000000;
    rd_resp = RESP_DECERR;
    if (s_axi_araddr == OFS_STAT) begin
      rd_resp = RESP_OKAY;
      rd_data[NUM_CTR-1:0] = ctr_hit;
      rd_data[STAT_PAGE_LSB +: 3] = page_open_now;
    end else if (s_axi_araddr[1:0] == 2'h0
                 && s_axi_araddr < OFS_STRIDE * 8'(NUM_CTR)) begin
      rd_resp = RESP_OKAY;
      for (int k = 0; k < NUM_CTR; k++) begin
        if (rd_idx == 8'(k)) begin
          if (s_axi_araddr[2:0] == OFS_SEL0[2:0]) begin
            rd_data[16:0] = sel_q[k];
          end else begin
            rd_data[CTR_W-1:0] = cnt_q[k];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: include/ues_pkg.sv
// Notes on behaviour
// - Code 30H: umask 04H counts channel 2 cancels, 07H sums all channels.
// - Code 31H: umasks 01H/02H/04H per channel priority updates, 07H sums all channels.
// - Matching high or critical request raises a priority update.
// - Code 33H umask 04H counts local force-acknowledge conflict messages.
// - Code 40H counts single-flit channels lacking shared and dedicated credit.
// - Code 40H umask 07H any link 0 channel, 38H any link 1 channel.
// - Code 41H counts multi-flit credit stalls, same umask layout.
// - Credit stall counting ignores arbitration grants of other channels.
// - Code 42H: umask 02H link 0, 08H link 1 header buffer busy.
// - Code 43H: umask 01H/02H snoops held back, peer probe tracker full.
// - Code 60H: umasks 01H/02H/04H count page-open commands per channel.
// - A page is opened before any read or write to it.
// - Code 61H: umasks 01H/02H/04H count idle-timer page closes.
// - An open page is closed by a precharge command.
`default_nettype none

package ues_pkg;

  // ----------------------------------------
  // Event codes
  // ----------------------------------------
  localparam logic [7:0] EV_CANCEL = 8'h30;
  localparam logic [7:0] EV_PRIO   = 8'h31;
  localparam logic [7:0] EV_FRCACK = 8'h33;
  localparam logic [7:0] EV_SF     = 8'h40;
  localparam logic [7:0] EV_MF     = 8'h41;
  localparam logic [7:0] EV_HDR    = 8'h42;
  localparam logic [7:0] EV_SNP    = 8'h43;
  localparam logic [7:0] EV_OPEN   = 8'h60;
  localparam logic [7:0] EV_CLOSE  = 8'h61;

  // ----------------------------------------
  // Unit masks
  // ----------------------------------------
  localparam logic [7:0] UM_01 = 8'h01;
  localparam logic [7:0] UM_02 = 8'h02;
  localparam logic [7:0] UM_04 = 8'h04;
  localparam logic [7:0] UM_07 = 8'h07;
  localparam logic [7:0] UM_08 = 8'h08;
  localparam logic [7:0] UM_10 = 8'h10;
  localparam logic [7:0] UM_20 = 8'h20;
  localparam logic [7:0] UM_38 = 8'h38;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0]  OFS_SEL0   = 8'h00;
  localparam logic [7:0]  OFS_CNT0   = 8'h04;
  localparam logic [7:0]  OFS_STRIDE = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h40;
  localparam int          SEL_CODE_LSB  = 0;
  localparam int          SEL_UMASK_LSB = 8;
  localparam int          SEL_EN_BIT    = 16;
  localparam logic [16:0] SEL_RST       = 17'h00000;
  localparam int          STAT_PAGE_LSB = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // ----------------------------------------
  // DRAM commands and page states
  // ----------------------------------------
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_OPEN = 2'h1;
  localparam logic [1:0] CMD_RW   = 2'h2;
  localparam logic [1:0] CMD_PRE  = 2'h3;

  typedef enum logic [1:0] {
    PG_CLOSED = 2'h0,
    PG_OPENED = 2'h1
  } ues_page_type;

endpackage

`default_nettype wire

// File: rtl/ues_event_mux.sv
`default_nettype none

module ues_event_mux
  import ues_pkg::*;
(
  input  wire logic [7:0] code,
  input  wire logic [7:0] umask,
  input  wire logic [2:0] cancel_ev,
  input  wire logic [2:0] prio_ev,
  input  wire logic       frc_ack_ev,
  input  wire logic [5:0] sf_stall,
  input  wire logic [5:0] mf_stall,
  input  wire logic [1:0] hdr_busy,
  input  wire logic [1:0] snp_stall,
  input  wire logic [2:0] open_ev,
  input  wire logic [2:0] close_ev,
  output logic            hit,
  output logic [1:0]      inc
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] sum3(input logic [2:0] v);
    sum3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  function automatic logic [2:0] pick3(input logic [7:0] um,
                                       input logic [2:0] v);
    pick3 = 3'h0;
    case (um)
      UM_01:   pick3 = {1'b1, 1'b0, v[0]};
      UM_02:   pick3 = {1'b1, 1'b0, v[1]};
      UM_04:   pick3 = {1'b1, 1'b0, v[2]};
      default: pick3 = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] pick6(input logic [7:0] um,
                                       input logic [5:0] v);
    pick6 = 3'h0;
    case (um)
      UM_01:   pick6 = {2'b10, v[0]};
      UM_02:   pick6 = {2'b10, v[1]};
      UM_04:   pick6 = {2'b10, v[2]};
      UM_08:   pick6 = {2'b10, v[3]};
      UM_10:   pick6 = {2'b10, v[4]};
      UM_20:   pick6 = {2'b10, v[5]};
      UM_07:   pick6 = {2'b10, |v[2:0]};
      UM_38:   pick6 = {2'b10, |v[5:3]};
      default: pick6 = 3'h0;
    endcase
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [2:0] sel;

  always_comb begin
    sel = 3'h0;
    case (code)
      EV_CANCEL: begin
        if (umask == UM_04) sel = {1'b1, 1'b0, cancel_ev[2]};
        else if (umask == UM_07) sel = {1'b1, sum3(cancel_ev)};
      end
      EV_PRIO: begin
        if (umask == UM_07) sel = {1'b1, sum3(prio_ev)};
        else sel = pick3(umask, prio_ev);
      end
      EV_FRCACK: begin
        if (umask == UM_04) sel = {2'b10, frc_ack_ev};
      end
      EV_SF:    sel = pick6(umask, sf_stall);
      EV_MF:    sel = pick6(umask, mf_stall);
      EV_HDR: begin
        if (umask == UM_02) sel = {2'b10, hdr_busy[0]};
        else if (umask == UM_08) sel = {2'b10, hdr_busy[1]};
      end
      EV_SNP:   sel = (umask == UM_01 || umask == UM_02) ?
                      {2'b10, |(snp_stall & umask[1:0])} : 3'h0;
      EV_OPEN:  sel = pick3(umask, open_ev);
      EV_CLOSE: sel = pick3(umask, close_ev);
      default:  sel = 3'h0;
    endcase
  end

  assign hit = sel[2];
  assign inc = sel[1:0];

endmodule

`default_nettype wire

// File: sim/ues_top_properties.sv
`default_nettype none

// ----------------------------------------
// Port checker
// ----------------------------------------
module ues_top_props
  import ues_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  crit_req_valid,
  input wire logic [2:0]  crit_req_match,
  input wire logic [2:0]  prio_update,
  input wire logic [2:0]  access_req,
  input wire logic [2:0]  idle_expired,
  input wire logic [2:0]  access_ack,
  input wire logic [5:0]  dram_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [2:0] pg_q;

  // Page state seen from issued commands
  always_ff @(posedge aclk) begin
    for (int c = 0; c < 3; c++) begin
      if (!aresetn) begin
        pg_q[c] <= 1'b0;
      end else if (dram_cmd[2*c +: 2] == CMD_OPEN) begin
        pg_q[c] <= 1'b1;
      end else if (dram_cmd[2*c +: 2] == CMD_PRE) begin
        pg_q[c] <= 1'b0;
      end
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_ch
    a_rw_page_open: assert property (
      dram_cmd[2*c +: 2] == CMD_RW |-> pg_q[c] && $past(access_req[c]))
      else $error("data access on a closed page");
    a_open_on_req: assert property (
      dram_cmd[2*c +: 2] == CMD_OPEN |-> !pg_q[c] && $past(access_req[c]))
      else $error("page open without request or twice");
    a_idle_precharge: assert property (
      pg_q[c] && dram_cmd[2*c +: 2] != CMD_PRE && !access_req[c]
      && idle_expired[c] |=> dram_cmd[2*c +: 2] == CMD_PRE)
      else $error("idle page not closed by precharge");
    a_ack_with_rw: assert property (
      access_ack[c] == (dram_cmd[2*c +: 2] == CMD_RW))
      else $error("access ack and data command differ");
  end

  a_prio_pulse: assert property (
    (crit_req_valid & crit_req_match) != 3'h0
    |=> prio_update == $past(crit_req_valid & crit_req_match))
    else $error("priority update missing");
  a_prio_cause: assert property (
    prio_update != 3'h0
    |-> prio_update == $past(crit_req_valid & crit_req_match))
    else $error("priority update without cause");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");

  c_prio: cover property (prio_update != 3'h0);
  c_open_rw: cover property (dram_cmd[1:0] == CMD_OPEN ##1
                             dram_cmd[1:0] == CMD_RW);
  c_pre: cover property (dram_cmd[1:0] == CMD_PRE);
endmodule

bind ues_top ues_top_props u_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .crit_req_valid(crit_req_valid), .crit_req_match(crit_req_match),
  .prio_update(prio_update), .access_req(access_req),
  .idle_expired(idle_expired), .access_ack(access_ack),
  .dram_cmd(dram_cmd)
);

`default_nettype wire

// File: sim/ues_top_bench.sv
`default_nettype none

module ues_top_bench
  import ues_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  cancel_req = 3'h0, crit_req_valid = 3'h0;
  logic [2:0]  crit_req_match = 3'h0, access_req = 3'h0;
  logic [2:0]  idle_expired = 3'h0, prio_update, access_ack;
  logic        frc_ack_sent = 1'b0, peer_probe_tracker_free = 1'b0;
  logic [1:0]  hdr_buf_busy = 2'h0, snoop_pending = 2'h0;
  logic [5:0]  sf_pending = 6'h00, sf_shared_credit = 6'h00;
  logic [5:0]  sf_dedicated_credit = 6'h00, mf_pending = 6'h00;
  logic [5:0]  mf_shared_credit = 6'h00, mf_dedicated_credit = 6'h00;
  logic [5:0]  dram_cmd;
  logic [31:0] seed = 32'h00015338, exp_cnt = 32'h0;
  logic [15:0] cur = 16'h0;
  logic        cur_en = 1'b0;
  logic [2:0]  pg = 3'h0;
  int          err_total = 0, n_tests = 0;

  localparam int NV = 33;
  localparam logic [15:0] TBL [38] = '{
    16'h3004, 16'h3007, 16'h3101, 16'h3102, 16'h3104, 16'h3107, 16'h3304,
    16'h4001, 16'h4002, 16'h4004, 16'h4008, 16'h4010, 16'h4020, 16'h4007,
    16'h4038, 16'h4101, 16'h4102, 16'h4104, 16'h4108, 16'h4110, 16'h4120,
    16'h4107, 16'h4138, 16'h4202, 16'h4208, 16'h4301, 16'h4302, 16'h6001,
    16'h6002, 16'h6004, 16'h6101, 16'h6102, 16'h6104, 16'h3001, 16'h3301,
    16'h4201, 16'h5001, 16'h3107};

  ues_top #(.NUM_CTR(2), .CTR_W(32)) uut (.*);

  always #10 aclk = ~aclk;

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  always @(posedge aclk) begin : model
    logic [5:0] v;
    logic [2:0] op, cl;
    logic       ok;
    op = access_req & ~pg;
    cl = pg & ~access_req & idle_expired;
    ok = 1'b0;
    for (int j = 0; j < NV; j++) if (TBL[j] == cur) ok = cur_en;
    case (cur[15:8])
      8'h30: v = {3'h0, cancel_req};
      8'h31: v = {3'h0, crit_req_valid & crit_req_match};
      8'h33: v = {3'h0, frc_ack_sent, 2'h0};
      8'h40: v = sf_pending & ~sf_shared_credit & ~sf_dedicated_credit;
      8'h41: v = mf_pending & ~mf_shared_credit & ~mf_dedicated_credit;
      8'h42: v = {2'h0, hdr_buf_busy[1], 1'b0, hdr_buf_busy[0], 1'b0};
      8'h43: v = {4'h0, snoop_pending & {2{~peer_probe_tracker_free}}};
      8'h60: v = {3'h0, op};
      8'h61: v = {3'h0, cl};
      default: v = 6'h00;
    endcase
    if (!aresetn) begin
      pg = 3'h0;
    end else begin
      pg = (pg | op) & ~cl;
      if (ok && (cur == 16'h3007 || cur == 16'h3107)) begin
        exp_cnt = exp_cnt + $countones(v & cur[5:0]);
      end else if (ok) begin
        exp_cnt = exp_cnt + 32'(|(v & cur[5:0]));
      end
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ----------------------------------------
  // Drivers and checks
  // ----------------------------------------
  task automatic drive(input logic on);
    logic [31:0] a, b, c;
    a = on ? rnd() : 32'h0;
    b = on ? rnd() : 32'h0;
    c = on ? rnd() : 32'h0;
    cancel_req <= a[2:0];
    crit_req_valid <= a[5:3];
    crit_req_match <= a[8:6];
    frc_ack_sent <= a[9];
    hdr_buf_busy <= a[11:10];
    snoop_pending <= a[13:12];
    peer_probe_tracker_free <= a[14];
    idle_expired <= a[17:15];
    access_req <= (access_req | a[20:18]) & ~access_ack;
    sf_pending <= b[5:0];
    sf_shared_credit <= b[11:6] & b[17:12];
    sf_dedicated_credit <= b[23:18] & b[29:24];
    mf_pending <= c[5:0];
    mf_shared_credit <= c[11:6] & c[17:12];
    mf_dedicated_credit <= c[23:18] & c[29:24];
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk_word(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reset();
    logic [31:0] d;
    logic [1:0]  r;
    foreach (TBL[i]) if (i < 5) begin
      rd((i == 4) ? OFS_STAT : 8'(4 * i), d, r);
      chk_resp(r, RESP_OKAY);
      chk_word(d, 32'h0);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin : main
    logic [31:0] d, v0;
    logic [1:0]  r;
    int          k;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reset();
    rd(8'h20, d, r);
    chk_resp(r, RESP_DECERR);
    chk_word(d, 32'h0);
    rd(8'h02, d, r);
    chk_resp(r, RESP_DECERR);
    wr(8'h24, 32'hFFFFFFFF, r);
    chk_resp(r, RESP_DECERR);
    s_axi_wstrb <= 4'h3;
    wr(8'h00, 32'h00013004, r);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, d, r);
    chk_word(d, 32'h00003004);
    foreach (TBL[i]) begin
      k = i % 2;
      cur = TBL[i];
      cur_en = (i != 37);
      wr(8'(8 * k), {15'h0, cur_en, cur[7:0], cur[15:8]}, r);
      chk_resp(r, RESP_OKAY);
      v0 = rnd();
      exp_cnt = v0;
      wr(8'(8 * k + 4), v0, r);
      repeat (32) begin
        drive(1'b1);
        @(posedge aclk);
      end
      repeat (8) begin
        drive(1'b0);
        @(posedge aclk);
      end
      rd(8'(8 * k + 4), d, r);
      chk_word(d, exp_cnt);
      rd(OFS_STAT, d, r);
      chk_word({28'h0, d[18:16], d[k] & cur_en},
               {28'h0, pg, i < NV && cur_en});
    end
    cur_en = 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reset();
    final_report();
  end
endmodule

`default_nettype wire
